// ===== dv/ppcd_far_model.sv
`timescale 1ns/10ps
module ppcd_far_model (
   input  wire logic                  i_ref_clk,
   input  wire logic [7:0]            i_lb_allow,
   output logic      [7:0]            o_lb_est,
   output logic      [3:0][7:0]       o_lane_expected,
   output logic      [3:0][7:0]       o_lane_received
);
   // Training reaches loopback master one cycle after permission
   always_ff @(posedge i_ref_clk) begin
      o_lb_est <= i_lb_allow;
   end
   // Fixed pattern bytes per lane
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         o_lane_expected[l] = 8'hA0 | 8'(l);
         o_lane_received[l] = 8'h50 | 8'(l);
      end
   end
endmodule // ppcd_far_model

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic            i_ref_clk = 1'b0;
   logic            i_srst = 1'b1;
   logic [11:0]     i_addr = 12'h000;
   logic            i_wr = 1'b0;
   logic            i_eeprom_load = 1'b0;
   logic [31:0]     i_wdata = 32'h0000_0000;
   logic [31:0]     o_rdata;
   logic [7:0]      lb_est, link_up = 8'h00, cfg_cpl = 8'h00, eidle = 8'h00;
   logic            user_test_pattern = 1'b0, prbs = 1'b0;
   logic [3:0][7:0] lane_exp, lane_rcv;
   logic [3:0]      lane_err = 4'h0;
   logic [7:0]      lb_allow, scr_off, l0s, l1, hold;
   logic [11:0]     skip;
   logic            utp_tx;
   int              n_errors = 0;
   int              num_checks = 0;
   always #12.5 i_ref_clk = ~i_ref_clk;
   ppcd_regs #(.PORTS(8), .LANES(4)) ppcd_regs_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
      .i_addr(i_addr), .i_wr(i_wr), .i_eeprom_load(i_eeprom_load), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .i_lb_master_est(lb_est), .i_link_up(link_up),
      .i_cfg_complete(cfg_cpl), .i_eidle_in_l0(eidle), .i_utp_enable(user_test_pattern),
      .i_prbs_enable(prbs), .i_lane_expected(lane_exp), .i_lane_received(lane_rcv),
      .i_lane_err(lane_err), .o_lb_master_allow(lb_allow), .o_scrambler_off(scr_off),
      .o_l0s_allow(l0s), .o_l1_allow(l1), .o_hold_detect_quiet(hold),
      .o_skip_interval(skip), .o_utp_transmit(utp_tx));
   ppcd_far_model ppcd_far_model_inst (.i_ref_clk(i_ref_clk), .i_lb_allow(lb_allow),
      .o_lb_est(lb_est), .o_lane_expected(lane_exp), .o_lane_received(lane_rcv));
   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
      @(negedge i_ref_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      i_eeprom_load = ee;
      @(negedge i_ref_clk);
      i_wr = 1'b0;
      i_eeprom_load = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(negedge i_ref_clk);
      i_addr = a;
      #1;
      chk(o_rdata, e);
   endtask
   task automatic t_reset();
      rd(12'h230, 32'h0000_0000);
      rd(12'h234, 32'h0000_049C);
      rd(12'h238, 32'h0000_0000);
      rd(12'h23C, 32'h0000_0000);
   endtask
   task automatic t_port();
      wr(12'h230, 32'h0080_0000, 1'b0);
      rd(12'h230, 32'h0000_0000);
      wr(12'h230, 32'h0000_0011, 1'b0);
      repeat (3) @(negedge i_ref_clk);
      rd(12'h230, 32'h0000_0099);
      chk({24'h0, lb_allow}, 32'h0000_0003);
   endtask
   task automatic t_scr();
      @(negedge i_ref_clk);
      link_up = 8'h00;
      wr(12'h230, 32'h0000_0022, 1'b1);
      repeat (3) @(negedge i_ref_clk);
      chk({24'h0, scr_off}, 32'h0000_0000);
      cfg_cpl = 8'h01;
      repeat (2) @(negedge i_ref_clk);
      chk({24'h0, scr_off}, 32'h0000_0001);
      wr(12'h230, 32'h0000_0000, 1'b0);
      wr(12'h230, 32'h0000_0002, 1'b0);
      repeat (2) @(negedge i_ref_clk);
      chk({24'h0, scr_off}, 32'h0000_0000);
      link_up = 8'h01;
      @(negedge i_ref_clk);
      chk({24'h0, scr_off}, 32'h0000_0001);
   endtask
   task automatic t_aspm();
      eidle = 8'hFF;
      wr(12'h230, 32'h0000_0000, 1'b0);
      #1;
      chk({16'h0, l0s, l1}, 32'h0000_FFFF);
      wr(12'h230, 32'h4444_4444, 1'b0);
      #1;
      chk({16'h0, l0s, l1}, 32'h0000_00FF);
   endtask
   task automatic t_skip();
      wr(12'h234, 32'hFFFF_F500, 1'b0);
      rd(12'h234, 32'h00FF_0500);
      chk({24'h0, hold}, 32'h0000_00FF);
      wr(12'h234, 32'h0000_0100, 1'b0);
      rd(12'h234, 32'h0000_049C);
      wr(12'h234, 32'h0000_0FFF, 1'b0);
      chk({20'h0, skip}, 32'h0000_0602);
      chk({24'h0, hold}, 32'h0000_0000);
   endtask
   task automatic t_diag();
      logic [1:0] s;
      wr(12'h230, 32'h0000_0001, 1'b0);
      repeat (3) @(negedge i_ref_clk);
      user_test_pattern = 1'b1;
      #1;
      chk({31'h0, utp_tx}, 32'h0000_0001);
      for (int l = 0; l < 4; l++) begin
         repeat (l + 1) begin
            @(negedge i_ref_clk);
            lane_err = 4'h1 << l;
            @(negedge i_ref_clk);
            lane_err = 4'h0;
         end
      end
      for (int l = 0; l < 4; l++) begin
         s = 2'(l);
         wr(12'h238, {6'h0, s, 24'h0}, 1'b0);
         rd(12'h238, {6'h0, s, 8'(l + 1), 6'h14, s, 6'h28, s});
      end
      lane_err = 4'h1;
      repeat (300) @(negedge i_ref_clk);
      lane_err = 4'h0;
      user_test_pattern = 1'b0;
      prbs = 1'b1;
      wr(12'h238, 32'h0000_0000, 1'b0);
      rd(12'h238, 32'h40FF_0000);
   endtask
   initial begin
      repeat (16) @(negedge i_ref_clk);
      i_srst = 1'b0;
      t_reset();
      t_port();
      t_scr();
      t_aspm();
      t_skip();
      t_diag();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      n_errors++;
      conclude();
   end
endmodule // tb_top

// ===== hw/ppcd_lane_diag.sv
`timescale 1ns/10ps
module ppcd_lane_diag #(
   parameter int LANES = 4
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_srst,
   input  wire logic                    i_utp_enable,
   input  wire logic                    i_prbs_enable,
   input  wire logic [LANES-1:0]        i_err_pulse,
   input  wire logic [LANES-1:0]        i_cnt_clear,
   output logic      [LANES-1:0][7:0]   o_err_count
);
   // Saturating per-lane error counters
   always_ff @(posedge i_ref_clk) begin
      for (int l = 0; l < LANES; l++) begin
         if (i_srst || i_cnt_clear[l]) begin
            o_err_count[l] <= ppcd_pkg::PPCD_BYTE_ZERO;
         end else if ((i_utp_enable || i_prbs_enable) && i_err_pulse[l]
                      && o_err_count[l] != ppcd_pkg::PPCD_ERR_MAX) begin
            o_err_count[l] <= o_err_count[l] + 8'h01; // [R12]
         end
      end
   end

   sat_cnt_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R12]
      (o_err_count[0] == ppcd_pkg::PPCD_ERR_MAX && !i_cnt_clear[0])
      |=> o_err_count[0] == ppcd_pkg::PPCD_ERR_MAX)
      else $error("Error count left saturation");
endmodule // ppcd_lane_diag

// ===== hw/ppcd_pkg.sv
package ppcd_pkg;
   localparam int          PPCD_PORTS          = 8;
   localparam int          PPCD_LANES          = 4;
   localparam logic [11:0] PPCD_ADDR_PORT_CMD  = 12'h0230;
   localparam logic [11:0] PPCD_ADDR_SKIP_CTL  = 12'h0234;
   localparam logic [11:0] PPCD_ADDR_QUAD0     = 12'h0238;
   // Per-port nibble layout of the port command register
   localparam int          PPCD_F_LB_REQ       = 0;
   localparam int          PPCD_F_SCR_OFF      = 1;
   localparam int          PPCD_F_RX_RESTRICT  = 2;
   localparam int          PPCD_F_LB_ACTIVE    = 3;
   localparam int          PPCD_NIBBLE         = 4;
   // Skip interval and port hold fields
   localparam int          PPCD_SKIP_LSB       = 0;
   localparam int          PPCD_SKIP_W         = 12;
   localparam logic [11:0] PPCD_SKIP_RESET     = 12'h049C;
   localparam logic [11:0] PPCD_SKIP_MIN       = 12'h049C;
   localparam logic [11:0] PPCD_SKIP_MAX       = 12'h0602;
   localparam int          PPCD_HOLD_LSB       = 16;
   // Diagnostic fields
   localparam int          PPCD_EXP_LSB        = 0;
   localparam int          PPCD_ACT_LSB        = 8;
   localparam int          PPCD_ERR_LSB        = 16;
   localparam int          PPCD_SEL_LSB        = 24;
   localparam int          PPCD_SRC_BIT        = 30;
   localparam logic [7:0]  PPCD_ERR_MAX        = 8'hFF;
   localparam logic [7:0]  PPCD_BYTE_ZERO      = 8'h00;
   localparam logic [31:0] PPCD_WORD_ZERO      = 32'h0000_0000;
endpackage

// ===== hw/ppcd_regs.sv
`timescale 1ns/10ps
// Functional notes
// [R1] Per-port nibble: request, scrambler-off, rx restrict, active; request permits loopback master.
// [R2] Read-only active bit mirrors training state machine loopback-master status.
// [R3] Scrambler-off loaded from EEPROM takes effect at Configuration Complete.
// [R4] Software scrambler-off while link up disables scrambler immediately, no retraining.
// [R5] Scrambler-off affects only own scrambler, never the link partner's.
// [R6] Restrict bit 0: receiver may enter L0s or L1 on idle set.
// [R7] Restrict bit 1: receiver may enter only L1, never L0s.
// [R8] 12-bit SKIP interval, reset 49Ch, kept within 49Ch to 602h.
// [R9] Per-port hold bit keeps training in Detect.Quiet; clear lets it proceed.
// [R10] Expected byte shown at bits 7:0 while quad 0 test pattern enabled.
// [R11] Received byte shown at bits 15:8 while test pattern enabled.
// [R12] Eight-bit saturating error count 0 to 255 at bits 23:16.
// [R13] Two-bit lane select chooses which quad 0 lane feeds bits 23:0.
// [R14] Bit 30 shows count source: 0 pattern errors, 1 pseudo-random errors.
// [R15] Pattern enable makes quad transmit 128-bit pattern in far-end loopback master.
// [R16] Port 5 active bit is read-only like all other ports.
module ppcd_regs #(
   parameter int PORTS = 8,
   parameter int LANES = 4
) (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_srst,
   input  wire logic [11:0]           i_addr,
   input  wire logic                  i_wr,
   input  wire logic                  i_eeprom_load,
   input  wire logic [31:0]           i_wdata,
   output logic      [31:0]           o_rdata,
   input  wire logic [PORTS-1:0]      i_lb_master_est,
   input  wire logic [PORTS-1:0]      i_link_up,
   input  wire logic [PORTS-1:0]      i_cfg_complete,
   input  wire logic [PORTS-1:0]      i_eidle_in_l0,
   input  wire logic                  i_utp_enable,
   input  wire logic                  i_prbs_enable,
   input  wire logic [LANES-1:0][7:0] i_lane_expected,
   input  wire logic [LANES-1:0][7:0] i_lane_received,
   input  wire logic [LANES-1:0]      i_lane_err,
   output logic      [PORTS-1:0]      o_lb_master_allow,
   output logic      [PORTS-1:0]      o_scrambler_off,
   output logic      [PORTS-1:0]      o_l0s_allow,
   output logic      [PORTS-1:0]      o_l1_allow,
   output logic      [PORTS-1:0]      o_hold_detect_quiet,
   output logic      [11:0]           o_skip_interval,
   output logic                       o_utp_transmit
);
   logic [PORTS-1:0] lb_req_reg;
   logic [PORTS-1:0] scr_off_reg;
   logic [PORTS-1:0] scr_from_eeprom_reg;
   logic [PORTS-1:0] rx_restrict_reg;
   logic [PORTS-1:0] lb_active_reg;
   logic [PORTS-1:0] scr_applied_reg;
   logic [PORTS-1:0] hold_reg;
   logic [11:0]      skip_reg;
   logic [11:0]      skip_next;
   logic [1:0]       lane_sel_reg;
   logic [LANES-1:0][7:0] err_count;
   logic [LANES-1:0] cnt_clear;
   logic             wr_cmd;
   logic             wr_skip;
   logic             wr_diag;

   function automatic logic [11:0] clamp_skip(input logic [11:0] v);
      if (v < ppcd_pkg::PPCD_SKIP_MIN) return ppcd_pkg::PPCD_SKIP_MIN;
      if (v > ppcd_pkg::PPCD_SKIP_MAX) return ppcd_pkg::PPCD_SKIP_MAX;
      return v;
   endfunction

   function automatic int nib_bit(input int p, input int f);
      return p * ppcd_pkg::PPCD_NIBBLE + f;
   endfunction

   assign wr_cmd  = i_wr && i_addr == ppcd_pkg::PPCD_ADDR_PORT_CMD;
   assign wr_skip = i_wr && i_addr == ppcd_pkg::PPCD_ADDR_SKIP_CTL;
   assign wr_diag = i_wr && i_addr == ppcd_pkg::PPCD_ADDR_QUAD0;
   assign cnt_clear = '0;
   assign skip_next = clamp_skip(i_wdata[ppcd_pkg::PPCD_SKIP_LSB +: ppcd_pkg::PPCD_SKIP_W]);

   // Port command writable bits
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         lb_req_reg          <= '0;
         scr_off_reg         <= '0;
         scr_from_eeprom_reg <= '0;
         rx_restrict_reg     <= '0;
      end else if (wr_cmd) begin
         for (int p = 0; p < PORTS; p++) begin
            lb_req_reg[p]      <= i_wdata[p*ppcd_pkg::PPCD_NIBBLE + ppcd_pkg::PPCD_F_LB_REQ];
            scr_off_reg[p]     <= i_wdata[p*ppcd_pkg::PPCD_NIBBLE + ppcd_pkg::PPCD_F_SCR_OFF];
            rx_restrict_reg[p] <= i_wdata[p*ppcd_pkg::PPCD_NIBBLE
                                          + ppcd_pkg::PPCD_F_RX_RESTRICT];
         end
         scr_from_eeprom_reg <= {PORTS{i_eeprom_load}};
      end
   end

   // Loopback master status, hardware only, writes ignored
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) lb_active_reg <= '0;
      else        lb_active_reg <= i_lb_master_est & lb_req_reg; // [R2] [R16]
   end

   // Scrambler disable application
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         scr_applied_reg <= '0;
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            if (!scr_off_reg[p])
               scr_applied_reg[p] <= 1'b0;
            else if (scr_from_eeprom_reg[p] && i_cfg_complete[p])
               scr_applied_reg[p] <= 1'b1; // [R3]
            else if (!scr_from_eeprom_reg[p] && i_link_up[p])
               scr_applied_reg[p] <= 1'b1; // [R4]
         end
      end
   end

   // SKIP interval and hold bits
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         skip_reg <= ppcd_pkg::PPCD_SKIP_RESET;
         hold_reg <= '0;
      end else if (wr_skip) begin
         skip_reg <= skip_next; // [R8]
         hold_reg <= i_wdata[ppcd_pkg::PPCD_HOLD_LSB +: PORTS];
      end
   end

   // Lane select
   always_ff @(posedge i_ref_clk) begin
      if (i_srst)       lane_sel_reg <= 2'h0;
      else if (wr_diag) lane_sel_reg <= i_wdata[ppcd_pkg::PPCD_SEL_LSB +: 2]; // [R13]
   end

   ppcd_lane_diag #(.LANES(LANES)) ppcd_lane_diag_inst (
      .i_ref_clk     (i_ref_clk),
      .i_srst        (i_srst),
      .i_utp_enable  (i_utp_enable),
      .i_prbs_enable (i_prbs_enable),
      .i_err_pulse   (i_lane_err),
      .i_cnt_clear   (cnt_clear),
      .o_err_count   (err_count)
   );

   assign o_lb_master_allow   = lb_req_reg; // [R1]
   // Only local scrambler control leaves this block
   assign o_scrambler_off     = scr_applied_reg; // [R5]
   assign o_l0s_allow         = ~rx_restrict_reg & i_eidle_in_l0; // [R6] [R7]
   assign o_l1_allow          = i_eidle_in_l0; // [R6] [R7]
   assign o_hold_detect_quiet = hold_reg; // [R9]
   assign o_skip_interval     = skip_reg;
   assign o_utp_transmit      = i_utp_enable && |lb_active_reg; // [R15]

   // Read mux
   always_comb begin
      o_rdata = ppcd_pkg::PPCD_WORD_ZERO;
      unique case (i_addr)
         ppcd_pkg::PPCD_ADDR_PORT_CMD: begin
            for (int p = 0; p < PORTS; p++) begin
               o_rdata[nib_bit(p, ppcd_pkg::PPCD_F_LB_REQ)]      = lb_req_reg[p];
               o_rdata[nib_bit(p, ppcd_pkg::PPCD_F_SCR_OFF)]     = scr_off_reg[p];
               o_rdata[nib_bit(p, ppcd_pkg::PPCD_F_RX_RESTRICT)] = rx_restrict_reg[p];
               o_rdata[nib_bit(p, ppcd_pkg::PPCD_F_LB_ACTIVE)]   = lb_active_reg[p]; // [R2]
            end
         end
         ppcd_pkg::PPCD_ADDR_SKIP_CTL: begin
            o_rdata[ppcd_pkg::PPCD_SKIP_LSB +: ppcd_pkg::PPCD_SKIP_W] = skip_reg;
            o_rdata[ppcd_pkg::PPCD_HOLD_LSB +: PORTS] = hold_reg;
         end
         ppcd_pkg::PPCD_ADDR_QUAD0: begin
            if (i_utp_enable) begin
               o_rdata[ppcd_pkg::PPCD_EXP_LSB +: 8] = i_lane_expected[lane_sel_reg]; // [R10]
               o_rdata[ppcd_pkg::PPCD_ACT_LSB +: 8] = i_lane_received[lane_sel_reg]; // [R11]
            end
            o_rdata[ppcd_pkg::PPCD_ERR_LSB +: 8] = err_count[lane_sel_reg]; // [R12] [R13]
            o_rdata[ppcd_pkg::PPCD_SEL_LSB +: 2] = lane_sel_reg;
            o_rdata[ppcd_pkg::PPCD_SRC_BIT]      = i_prbs_enable; // [R14]
         end
         default: o_rdata = ppcd_pkg::PPCD_WORD_ZERO;
      endcase
   end

   skip_range_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R8]
      skip_reg >= ppcd_pkg::PPCD_SKIP_MIN && skip_reg <= ppcd_pkg::PPCD_SKIP_MAX)
      else $error("Skip interval out of range");
   lb_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R1]
      (lb_active_reg & ~$past(lb_req_reg)) == '0)
      else $error("Loopback active without request");
   lb_status_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R2]
      lb_active_reg == $past(i_lb_master_est & lb_req_reg))
      else $error("Active bit does not follow training");
   lb_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R16]
      (wr_cmd && !i_lb_master_est[5]) |=> !lb_active_reg[5])
      else $error("Port 5 active bit took a write");
   scr_up_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R4]
      (scr_off_reg[0] && !scr_from_eeprom_reg[0] && i_link_up[0]) |=> o_scrambler_off[0])
      else $error("Scrambler not disabled on live link");
   scr_ee_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R3]
      (!scr_applied_reg[0] && scr_from_eeprom_reg[0] && !i_cfg_complete[0])
      |=> !scr_applied_reg[0])
      else $error("Loaded scrambler disable before config complete");
   l0s_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R7]
      rx_restrict_reg[0] |-> !o_l0s_allow[0])
      else $error("L0s allowed while restricted");
   l0s_ok_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R6]
      (!rx_restrict_reg[0] && i_eidle_in_l0[0]) |-> o_l0s_allow[0] && o_l1_allow[0])
      else $error("Low power entry blocked");
   hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R9]
      wr_skip |=> o_hold_detect_quiet == $past(i_wdata[ppcd_pkg::PPCD_HOLD_LSB +: PORTS]))
      else $error("Hold bits not taken");
   sel_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R13]
      wr_diag |=> lane_sel_reg == $past(i_wdata[ppcd_pkg::PPCD_SEL_LSB +: 2]))
      else $error("Lane select not taken");
   utp_tx_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R15]
      (i_utp_enable && lb_active_reg != '0) |-> o_utp_transmit)
      else $error("Pattern transmit not enabled");
   diag_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R10] [R11]
      (i_addr == ppcd_pkg::PPCD_ADDR_QUAD0 && !i_utp_enable)
      |-> o_rdata[ppcd_pkg::PPCD_EXP_LSB +: 8] == ppcd_pkg::PPCD_BYTE_ZERO
          && o_rdata[ppcd_pkg::PPCD_ACT_LSB +: 8] == ppcd_pkg::PPCD_BYTE_ZERO)
      else $error("Pattern bytes shown while disabled");
   src_bit_a: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [R14]
      (i_addr == ppcd_pkg::PPCD_ADDR_QUAD0)
      |-> o_rdata[ppcd_pkg::PPCD_SRC_BIT] == i_prbs_enable)
      else $error("Count source bit wrong");
endmodule // ppcd_regs
